// file: logic/sac_pkg.sv
// Package: constants and carrier types for the SAR conversion sequencer and serial readout
package sac_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_MHZ       = 50;
  localparam int unsigned CONV_MIN_NS   = 500;
  localparam int unsigned CONV_MAX_NS   = 1300;
  // Least time rounds up, longest rounds down
  localparam int unsigned CONV_MIN_CYC  = (CONV_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CONV_MAX_CYC  = (CONV_MAX_NS * CLK_MHZ) / 1000;
  localparam int unsigned CONV_DEF_CYC  = CONV_MIN_CYC + 8;
  localparam int unsigned DATA_W        = 16;
  localparam int unsigned BIT_CNT_W     = 5;
  localparam int unsigned CNT_W         = 8;
  localparam logic [BIT_CNT_W-1:0] LAST_FALL = 5'h10;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    SAC_ACQUIRE,
    SAC_CONVERT
  } sac_phase_t;

  typedef enum logic {
    SAC_MODE_DAISY,
    SAC_MODE_CS
  } sac_mode_t;

  // Serial output pin as value and enable
  typedef struct packed {
    logic o;
    logic oe;
  } sac_pin_t;

  // Analog-side controls
  typedef struct packed {
    logic sample;
    logic isolate;
    logic power_down;
  } sac_analog_t;

endpackage : sac_pkg

// file: logic/sac_core.sv
// Module: conversion sequencing and serial result readout of a 16-bit SAR converter
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Sample inputs, isolate them during conversion
// - Internal clock times conversion, 500 to 1300 ns
// - Reconnect array, enter acquisition after conversion
// - Power down in acquisition, keep result
// - Serial clock only shifts result bits
// - SPI framing, host clocks and captures
// - Strobe rise samples select: chip-select or daisy
// - In chip-select mode, select fall drives MSB, clock falls next
// - Release output at 16th fall or select rise
module sac_core #(
  parameter int unsigned CONV_CYC = sac_pkg::CONV_DEF_CYC
) (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Host pins
  input  wire logic               conversion_start_strobe_i,
  input  wire logic               sel_n_i,
  input  wire logic               sclk_i,
  output var  logic               sdo_o,
  output var  logic               sdo_oe_o,
  // Converter core
  input  wire logic [15:0]        sar_result_i,
  output var  logic               sample_o,
  output var  logic               isolate_o,
  output var  logic               power_down_o,
  output var  logic               mode_cs_o,
  output var  logic               busy_o
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic [2:0] prev_q;
  logic       cnv_sync;
  logic       sel_sync;
  logic       sck_sync;

  // The link clock is only sampled here, never used as a clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Idle pin levels, so leaving reset shows no false edge
      meta_q <= '1;
      sync_q <= '1;
      prev_q <= '1;
    end else begin
      meta_q <= {conversion_start_strobe_i, sel_n_i, sclk_i};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign cnv_sync = sync_q[2];
  assign sel_sync = sync_q[1];
  assign sck_sync = sync_q[0];

  // ****************************************
  // Edge detection
  // ****************************************
  logic cnv_rise;
  logic sel_fall;
  logic sel_rise;
  logic sck_fall;

  assign cnv_rise = cnv_sync & ~prev_q[2];
  assign sel_fall = ~sel_sync & prev_q[1];
  assign sel_rise = sel_sync & ~prev_q[1];
  assign sck_fall = ~sck_sync & prev_q[0];

  // ****************************************
  // Conversion sequencer
  // ****************************************
  sac_pkg::sac_phase_t         phase_q, phase_d;
  logic [sac_pkg::CNT_W-1:0]   cnt_q, cnt_d;
  logic [15:0]                 res_q, res_d;
  sac_pkg::sac_mode_t          mode_q, mode_d;
  sac_pkg::sac_analog_t        ana_q, ana_d;
  logic                        done;

  // Internal count is bounded, so the conversion ends inside the window when CONV_CYC is 25 to 65 (default 33)
  assign done = (cnt_q == sac_pkg::CNT_W'(CONV_CYC - 1));

  always_comb begin
    phase_d = phase_q;
    cnt_d   = cnt_q;
    res_d   = res_q;
    mode_d  = mode_q;
    ana_d   = ana_q;
    ana_d.sample = 1'b0;
    unique case (phase_q)
      sac_pkg::SAC_ACQUIRE: begin
        // Strobe rises while converting never reach this branch
        if (cnv_rise) begin
          mode_d  = sel_sync ? sac_pkg::SAC_MODE_CS : sac_pkg::SAC_MODE_DAISY;
          phase_d = sac_pkg::SAC_CONVERT;
          cnt_d   = '0;
          ana_d   = '{sample: 1'b1, isolate: 1'b1, power_down: 1'b0};
        end
      end
      sac_pkg::SAC_CONVERT: begin
        cnt_d = cnt_q + sac_pkg::CNT_W'(1);
        if (done) begin
          phase_d = sac_pkg::SAC_ACQUIRE;
          // Result taken in the last converting cycle
          res_d   = sar_result_i;
          ana_d   = '{sample: 1'b0, isolate: 1'b0, power_down: 1'b1};
        end
      end
      default: phase_d = sac_pkg::SAC_ACQUIRE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_q <= sac_pkg::SAC_ACQUIRE;
      cnt_q   <= '0;
      res_q   <= 16'h0000;
      mode_q  <= sac_pkg::SAC_MODE_CS;
      ana_q   <= '{sample: 1'b0, isolate: 1'b0, power_down: 1'b1};
    end else begin
      phase_q <= phase_d;
      cnt_q   <= cnt_d;
      res_q   <= res_d;
      mode_q  <= mode_d;
      ana_q   <= ana_d;
    end
  end

  // ****************************************
  // Serial readout
  // ****************************************
  logic [15:0]                     shf_q, shf_d;
  logic [sac_pkg::BIT_CNT_W-1:0]   nfall_q, nfall_d;
  sac_pkg::sac_pin_t               pin_q, pin_d;
  logic                            reading;

  // Daisy-chain shifting is not carried: the output stays released there
  // Readout only in chip-select mode, acquisition phase, strobe held high
  assign reading = (phase_q == sac_pkg::SAC_ACQUIRE) && (mode_q == sac_pkg::SAC_MODE_CS)
                   && cnv_sync;

  always_comb begin
    shf_d   = shf_q;
    nfall_d = nfall_q;
    pin_d   = pin_q;
    if (cnv_rise || sel_rise || !reading) begin
      pin_d = '{o: 1'b0, oe: 1'b0};
    end else if (sel_fall) begin
      // Whole word loaded at selection, so a later conversion cannot tear it
      shf_d   = res_q;
      nfall_d = '0;
      pin_d   = '{o: res_q[15], oe: 1'b1};
    end else if (pin_q.oe && sck_fall) begin
      nfall_d = nfall_q + sac_pkg::BIT_CNT_W'(1);
      shf_d   = {shf_q[14:0], 1'b0};
      // Sixteenth fall ends the word
      if (nfall_d == sac_pkg::LAST_FALL) begin
        pin_d = '{o: 1'b0, oe: 1'b0};
      end else begin
        // Next lower bit sits one place below the bit on the pin
        pin_d.o = shf_q[14];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shf_q   <= 16'h0000;
      nfall_q <= '0;
      pin_q   <= '{o: 1'b0, oe: 1'b0};
    end else begin
      shf_q   <= shf_d;
      nfall_q <= nfall_d;
      pin_q   <= pin_d;
    end
  end

  // ****************************************
  // Busy flag
  // ****************************************
  logic busy_q;
  logic busy_d;

  // Follows the next phase, so it moves together with isolate
  always_comb begin
    busy_d = (phase_d == sac_pkg::SAC_CONVERT);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  assign sdo_o        = pin_q.o;
  assign sdo_oe_o     = pin_q.oe;
  assign sample_o     = ana_q.sample;
  assign isolate_o    = ana_q.isolate;
  assign power_down_o = ana_q.power_down;
  assign mode_cs_o    = 1'(mode_q);
  assign busy_o       = busy_q;

endmodule : sac_core

`default_nettype wire

// file: verification/sac_chk_sva.sv
// Checker: conversion timing and serial output enable
`timescale 1ns/10ps
`default_nettype none
module sac_chk #(parameter int unsigned CONV_CYC = sac_pkg::CONV_DEF_CYC) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic conversion_start_strobe_i,
  input wire logic sel_n_i,
  input wire logic sdo_oe_o,
  input wire logic sample_o,
  input wire logic isolate_o,
  input wire logic power_down_o,
  input wire logic busy_o
);
  logic [7:0] cnt_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Counts cycles spent converting
  always_ff @(posedge clk_i) cnt_q <= (rst_i || !isolate_o) ? 8'h00 : cnt_q + 8'h01;
  sequence s_pulse;
    busy_o ##1 (!sample_o && busy_o);
  endsequence
  a_sample_pulse: assert property ($rose(sample_o) |-> s_pulse)
    else $error("sample width");
  a_isolate_start: assert property ($rose(isolate_o) |-> sample_o && !power_down_o)
    else $error("isolate start");
  a_conv_exact: assert property ($fell(isolate_o) |-> cnt_q == CONV_CYC)
    else $error("conversion length");
  a_conv_window: assert property ($fell(isolate_o) |-> cnt_q >= sac_pkg::CONV_MIN_CYC
    && cnt_q <= sac_pkg::CONV_MAX_CYC) else $error("conversion window");
  a_acq_entry: assert property ($fell(isolate_o) |-> power_down_o && !busy_o)
    else $error("acquire entry");
  a_phase_excl: assert property (power_down_o != isolate_o)
    else $error("phase overlap");
  a_busy_quiet: assert property (busy_o |-> !sdo_oe_o)
    else $error("driven while busy");
  a_strobe_low: assert property (!conversion_start_strobe_i [*5] |-> !sdo_oe_o)
    else $error("driven with strobe low");
  a_sel_high: assert property (sel_n_i [*5] |-> !sdo_oe_o)
    else $error("driven while deselected");
endmodule : sac_chk
`default_nettype wire

// file: verification/sac_host.sv
// Host model: starts conversions and reads results as serial master
`timescale 1ns/10ps
`default_nettype none
module sac_host (
  input wire logic clk_i,
  input wire logic sdo_i,
  input wire logic sdo_oe_i,
  output var logic strobe_o,
  output var logic sel_n_o,
  output var logic sclk_o
);
  initial begin
    strobe_o = 1'b1;
    sel_n_o = 1'b1;
    sclk_o = 1'b1;
  end
  task automatic conv(input logic cs);
    @(posedge clk_i);
    sel_n_o <= cs;
    strobe_o <= 1'b0;
    repeat (6) @(posedge clk_i);
    strobe_o <= 1'b1;
    repeat (70) @(posedge clk_i);
  endtask : conv
  // Each bit is taken just before the fall that replaces it
  task automatic read(output logic [15:0] d, output logic ok);
    ok = 1'b1;
    @(posedge clk_i);
    sel_n_o <= 1'b0;
    repeat (8) @(posedge clk_i);
    for (int i = 15; i >= 0; i--) begin
      d[i] = sdo_i;
      ok &= sdo_oe_i;
      sclk_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
    end
    sel_n_o <= 1'b1;
  endtask : read
endmodule : sac_host
`default_nettype wire

// file: verification/tb_sar_adc_conversion_serial_readout.sv
// Testbench: conversion sequencing and serial readout
`timescale 1ns/10ps
`default_nettype none
module tb_sar_adc_conversion_serial_readout;
  logic clk_i, rst_i, strobe, sel_n, sclk, sdo_o, sdo_oe_o, mode_cs_o, power_down_o, busy_o;
  logic [15:0] sar_result_i, d;
  logic ok;
  int error_cnt = 0;
  int n_checks = 0;
  sac_core dut (.clk_i(clk_i), .rst_i(rst_i), .conversion_start_strobe_i(strobe),
    .sel_n_i(sel_n), .sclk_i(sclk), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
    .sar_result_i(sar_result_i), .sample_o(), .isolate_o(), .power_down_o(power_down_o),
    .mode_cs_o(mode_cs_o), .busy_o(busy_o));
  sac_host host (.clk_i(clk_i), .sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o), .strobe_o(strobe),
    .sel_n_o(sel_n), .sclk_o(sclk));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_sim;
    if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  // Leaving reset with the pins idle must not start a conversion
  task automatic t_idle;
    repeat (8) @(negedge clk_i);
    chk("idle busy", busy_o, 1'b0);
    chk("idle oe", sdo_oe_o, 1'b0);
    chk("idle pd", power_down_o, 1'b1);
  endtask : t_idle
  // Result must survive a changing converter input
  task automatic t_read(input logic [15:0] v);
    sar_result_i <= v;
    host.conv(1'b1);
    sar_result_i <= ~v;
    @(negedge clk_i);
    chk("mode", mode_cs_o, 1'b1);
    chk("pd", power_down_o, 1'b1);
    chk("busy", busy_o, 1'b0);
    host.read(d, ok);
    @(negedge clk_i);
    chk("oe end", sdo_oe_o, 1'b0);
    chk("data", d, v);
    chk("oe", ok, 1'b1);
  endtask : t_read
  task automatic t_daisy;
    host.conv(1'b0);
    @(negedge clk_i);
    chk("mode", mode_cs_o, 1'b0);
    host.read(d, ok);
    chk("daisy oe", ok, 1'b0);
  endtask : t_daisy
  task automatic t_abort;
    host.conv(1'b1);
    host.sel_n_o <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk("oe on", sdo_oe_o, 1'b1);
    host.sel_n_o <= 1'b1;
    repeat (6) @(negedge clk_i);
    chk("oe abort", sdo_oe_o, 1'b0);
  endtask : t_abort
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    error_cnt++;
    end_sim();
  end
  initial begin
    rst_i = 1'b1;
    sar_result_i = 16'h0000;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_idle();
    t_read(16'hA5C3);
    t_read(16'h8001);
    t_daisy();
    t_abort();
    end_sim();
  end
endmodule : tb_sar_adc_conversion_serial_readout
bind sac_core sac_chk #(.CONV_CYC(CONV_CYC)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .conversion_start_strobe_i(conversion_start_strobe_i), .sel_n_i(sel_n_i),
  .sdo_oe_o(sdo_oe_o), .sample_o(sample_o), .isolate_o(isolate_o),
  .power_down_o(power_down_o), .busy_o(busy_o));
`default_nettype wire
